// File: bench/had_decoder_tb_top.sv
// self-checking bench for the host address decoder
`timescale 1ns/1ps
module had_decoder_tb_top;
   import had_pkg::*;
   typedef struct {had_tgt_e t; logic [31:0] a; logic [7:0] b; logic [1:0] m; logic w;} had_exp_s;
   localparam logic [6:0] RD = 7'h08;
   localparam logic [6:0] WR = 7'h48;
   logic        clock = 1'h0, rstn = 1'h0, req_valid = 1'h0, req_write = 1'h0, req_mgmt_mode = 1'h0;
   logic        req_writeback_attr = 1'h0, req_snooped = 1'h0, req_writeback_cycle = 1'h0, attr_wr = 1'h0;
   logic        req_implicit_writeback = 1'h0, req_full_line = 1'h0, attr_re = 1'h0, attr_we = 1'h0;
   logic        hole_en = 1'h0, low_mgmt_segment_en = 1'h0, ext_mgmt_memory_en = 1'h0, apic_pcie_en = 1'h0;
   logic        high_mgmt_segment_en = 1'h0, pcie_window_en = 1'h0, kbd_text_en = 1'h0;
   logic [3:0]  attr_sel = 4'h0;
   logic [31:0] req_addr = 32'h0, kbd_text_mmio_base = 32'hE000_0000, a, r;
   logic [7:0]  req_be = 8'h00;
   logic [11:0] low_usable_top = 12'h040, pcie_window_base = 12'h100, pcie_window_limit = 12'h1FF;
   logic [6:0]  gfx_stolen_mb = 7'h01;
   logic [2:0]  ext_gfx_int_pin = 3'h4;
   had_src_e    req_src = SRC_HOST;
   had_lms_e    low_mgmt_segment_size = LMS_1MB;
   logic        req_ready, rsp_valid, rsp_write, rsp_host_term, hang;
   had_tgt_e    rsp_target;
   logic [31:0] rsp_addr;
   logic [7:0]  rsp_be;
   logic [12:0] attr_re_map, attr_we_map;
   logic [2:0]  int_pin_integrated_graphics, int_pin_graphics_pcie_port, int_pin_ext_graphics;
   logic [2:0]  int_pin_redirection_function, int_pin_host_interface_function, int_pin_keyboard_text_function;
   int unsigned err_total = 0, tests_run = 0, taken_cnt, sent = 0;
   had_exp_s    expq[$], x;
   had_lms_e    lms[3] = '{LMS_1MB, LMS_2MB, LMS_8MB};
   logic [11:0] szmb[3] = '{LMS_MB_1, LMS_MB_2, LMS_MB_8};

   had_decoder i_dut (.*);
   had_far_side i_far (.clock(clock), .rstn(rstn), .rsp_valid(rsp_valid), .taken_cnt(taken_cnt));

   // free-running 50 MHz clock
   always #10 clock = ~clock;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      if (err_total == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // one request per edge; m of 2'h1 means no answer, m[1] asks for a host termination check
   task automatic send(input logic [31:0] ad, input had_src_e s, input logic [6:0] f, input had_tgt_e t,
                       input logic [31:0] ea, input logic [1:0] m);
      req_valid = 1'h1;
      req_addr = ad;
      req_src = s;
      {req_write, req_mgmt_mode, req_writeback_attr, req_snooped, req_writeback_cycle,
       req_implicit_writeback, req_full_line} = f;
      req_be = 8'($urandom);
      if (m != 2'h1) begin
         expq.push_back('{t, ea, (t == TGT_INVALID && f[6]) ? 8'h00 : req_be, m, f[6]});
         sent++;
      end
      @(posedge clock);
      #2;
   endtask

   task automatic go(input logic [31:0] ad, input had_src_e s, input logic [6:0] f, input had_tgt_e t);
      send(ad, s, f, t, (t == TGT_INVALID) ? 32'h0 : ad, 2'h0);
   endtask

   // attribute load is a lone pulse, so an idle edge follows it
   task automatic setattr(input int p, input logic re, input logic we);
      req_valid = 1'h0;
      attr_wr = 1'h1;
      attr_sel = 4'(p);
      attr_re = re;
      attr_we = we;
      @(posedge clock);
      #2;
      attr_wr = 1'h0;
      @(posedge clock);
      #2;
   endtask

   // bounded wait until every noted answer has shown up
   task automatic drain;
      req_valid = 1'h0;
      for (int i = 0; i < 8 && expq.size() > 0; i++) begin
         @(posedge clock);
         #12;
      end
      if (expq.size() > 0) begin
         err_total++;
         tally_and_finish();
      end
      @(posedge clock);
      #2;
   endtask

   // answers are judged mid-cycle, oldest note first
   always @(negedge clock) begin
      if (rstn === 1'h1 && rsp_valid === 1'h1) begin
         if (expq.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            x = expq.pop_front();
            check(32'(rsp_target), 32'(x.t));
            check(rsp_addr, x.a);
            check(32'(rsp_be), 32'(x.b));
            check(32'(rsp_write), 32'(x.w));
            if (x.m[1]) check(32'(rsp_host_term), 32'(x.m[0]));
         end
      end
   end

   initial begin
      void'($urandom(32'h4963));
      repeat (8) @(posedge clock);
      #2;
      // values held while reset is still low
      check(32'(int_pin_ext_graphics), 32'(INT_PIN_A));
      check(32'(hang), 32'h0);
      check(32'(rsp_valid), 32'h0);
      rstn = 1'h1;
      @(posedge clock);
      #2;
      // reset state of attributes and fixed interrupt pins; external card pin already loaded from ext_gfx_int_pin
      check(32'(attr_re_map), 32'h0);
      check(32'(attr_we_map), 32'h0);
      check(32'(int_pin_integrated_graphics), 32'(INT_PIN_A));
      check(32'(int_pin_graphics_pcie_port), 32'(INT_PIN_A));
      check(32'(int_pin_redirection_function), 32'(INT_PIN_B));
      check(32'(int_pin_host_interface_function), 32'(INT_PIN_C));
      check(32'(int_pin_keyboard_text_function), 32'(INT_PIN_A));
      check(32'(int_pin_ext_graphics), 32'h4);
      go(SYS_BIOS_LO, SRC_HOST, RD, TGT_LINK);
      // each piece gets a state by index, so all four states occur
      for (int p = 0; p < 13; p++) begin
         setattr(p, p[0], p[1]);
         a = (p < 12) ? PAM_LO + 32'(p << 14) + ($urandom % 16384) : SYS_BIOS_LO + ($urandom % 65536);
         go(a, SRC_HOST, RD, p[0] ? TGT_DRAM : TGT_LINK);
         go(a, SRC_LINK, WR, p[1] ? TGT_DRAM : TGT_LINK);
      end
      setattr(13, 1'h1, 1'h1);
      check(32'(attr_re_map), 32'h0AAA);
      check(32'(attr_we_map), 32'h0CCC);
      go(PAM_LO, SRC_LINK, 7'h00, TGT_DRAM);
      go(SYS_BIOS_LO, SRC_PCIE, 7'h40, TGT_DRAM);
      go(SYS_BIOS_LO, SRC_PCIE, RD, TGT_LINK);
      // main memory, isa hole and low management segment
      go(32'h0020_0000 + ($urandom % 32'h0010_0000), SRC_HOST, RD, TGT_DRAM);
      hole_en = 1'h1;
      go(HOLE_LO + ($urandom % 32'h0010_0000), SRC_HOST, WR, TGT_LINK);
      go(HOLE_LO - 32'h1, SRC_HOST, RD, TGT_DRAM);
      low_mgmt_segment_en = 1'h1;
      ext_mgmt_memory_en = 1'h1;
      a = 32'h03E0_0000 + ($urandom % 32'h0010_0000);
      go(a, SRC_HOST, RD | 7'h30, TGT_DRAM);
      go(a, SRC_LINK, WR, TGT_INVALID);
      go(a, SRC_IGFX, RD, TGT_INVALID);
      go(a, SRC_HOST, RD | 7'h20, TGT_INVALID);
      go(a, SRC_HOST, RD | 7'h10, TGT_INVALID);
      go(a, SRC_HOST, WR | 7'h14, TGT_DRAM);
      for (int i = 0; i < 3; i++) begin
         low_mgmt_segment_size = lms[i];
         a = 32'h03F0_0000 - {szmb[i], 20'h00000};
         go(a, SRC_PCIE, RD, TGT_INVALID);
         go(a - 32'h1, SRC_LINK, RD, TGT_DRAM);
      end
      // pci range; windows kept clear of the fixed sub-ranges
      go(32'h0800_0000, SRC_HOST, RD, TGT_LINK);
      pcie_window_en = 1'h1;
      go(32'h1000_0000, SRC_HOST, WR, TGT_PCIE);
      go(32'h1FFF_FFFF, SRC_LINK, RD, TGT_PCIE);
      go(32'h0FFF_FFFF, SRC_HOST, RD, TGT_LINK);
      go(32'h2000_0000, SRC_HOST, RD, TGT_LINK);
      kbd_text_en = 1'h1;
      go(kbd_text_mmio_base + ($urandom % 4096), SRC_HOST, RD, TGT_DRAM);
      go(APIC_LO, SRC_HOST, RD, TGT_LINK);
      go(APIC_PCIE_LO, SRC_HOST, RD, TGT_LINK);
      apic_pcie_en = 1'h1;
      go(APIC_PCIE_LO, SRC_HOST, WR, TGT_PCIE);
      go(APIC_HI, SRC_LINK, RD, TGT_PCIE);
      go(APIC_DEF_HI, SRC_HOST, RD, TGT_LINK);
      // high segment remap, termination and refusal
      go(HIGH_MGMT_SEGMENT_LO, SRC_HOST, RD, TGT_LINK);
      high_mgmt_segment_en = 1'h1;
      a = HIGH_MGMT_SEGMENT_LO + ($urandom % 32'h0002_0000);
      r = MANAGEMENT_MEMORY_REMAP + (a - HIGH_MGMT_SEGMENT_LO);
      send(a, SRC_HOST, RD | 7'h20, TGT_DRAM, r, 2'h2);
      send(a, SRC_HOST, RD, TGT_INVALID, 32'h0, 2'h3);
      send(a, SRC_HOST, WR | 7'h14, TGT_DRAM, r, 2'h0);
      send(a, SRC_LINK, RD, TGT_INVALID, 32'h0, 2'h2);
      go(a, SRC_PCIE, WR, TGT_INVALID);
      send(a, SRC_HOST, WR | 7'h11, TGT_DRAM, r, 2'h0);
      send(a, SRC_HOST, WR | 7'h12, TGT_DRAM, r, 2'h0);
      drain();
      check(taken_cnt, sent);
      // implicit writeback steered to the link wedges the hub
      send(PAM_LO, SRC_LINK, 7'h0A, TGT_LINK, 32'h0, 2'h1);
      drain();
      check(32'(hang), 32'h1);
      check(32'(req_ready), 32'h0);
      rstn = 1'h0;
      @(posedge clock);
      #2;
      rstn = 1'h1;
      check(32'(hang), 32'h0);
      check(32'(req_ready), 32'h1);
      go(32'h0010_0000, SRC_HOST, RD, TGT_DRAM);
      drain();
      tally_and_finish();
   end
endmodule // had_decoder_tb_top

// File: bench/had_far_side.sv
// far-side sink that tallies every routed cycle
`timescale 1ns/1ps
module had_far_side (
   input  wire logic  clock,
   input  wire logic  rstn,
   input  wire logic  rsp_valid,
   output int unsigned taken_cnt
);
   // the real targets never push back, so every answer is taken at once
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         taken_cnt <= 0;
      end else if (rsp_valid) begin
         taken_cnt <= taken_cnt + 1;
      end
   end
endmodule // had_far_side

// File: src/had_attr_if.sv
// lookup path between the decoder and the attribute map
`timescale 1ns/1ps
interface had_attr_if;
   logic [31:0] addr;
   logic        is_write;
   logic        hit;
   logic        enabled;
   modport map (input addr, input is_write, output hit, output enabled);
   modport dec (output addr, output is_write, input hit, input enabled);
endinterface

// File: src/had_attr_map.sv
// per-piece read/write attribute store for the legacy bios area
`timescale 1ns/1ps
module had_attr_map
   import had_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       attr_wr,
   input  wire logic [3:0] attr_sel,
   input  wire logic       attr_re,
   input  wire logic       attr_we,
   output logic [12:0]     attr_re_map,
   output logic [12:0]     attr_we_map,
   had_attr_if.map         lk
);
   import had_pkg::*;

   logic [12:0] re_q;
   logic [12:0] we_q;
   logic [5:0]  raw_idx;
   logic [3:0]  seg_idx;
   logic        sel_ok;

   // 16 KB pieces below F0000, one 64 KB piece above
   assign raw_idx = 6'(lk.addr[19:PAM_SEG_SHIFT] - PAM_SEG_FIRST);
   assign seg_idx = had_in_rng(lk.addr, SYS_BIOS_LO, PAM_HI) ? PAM_SYS_IDX : raw_idx[3:0];
   assign lk.hit  = had_in_rng(lk.addr, PAM_LO, PAM_HI);
   // separate enables give ro, wo, rw and disabled
   assign lk.enabled = lk.is_write ? we_q[seg_idx] : re_q[seg_idx];
   assign sel_ok  = attr_sel <= PAM_SYS_IDX;
   assign attr_re_map = re_q;
   assign attr_we_map = we_q;

   // reset leaves every piece disabled, so bios fetches go to the link
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         re_q <= PAM_RE_RST;
         we_q <= PAM_WE_RST;
      end else if (attr_wr && sel_ok) begin
         re_q[attr_sel] <= attr_re;
         we_q[attr_sel] <= attr_we;
      end
   end

   AST_ATTR_HOLD: assert property (@(posedge clock) disable iff (!rstn)
      !attr_wr |=> $stable(re_q) && $stable(we_q)) else $error("attribute changed without a write");
   AST_ATTR_LOAD: assert property (@(posedge clock) disable iff (!rstn)
      attr_wr && attr_sel == 4'h3 |=> re_q[3] == $past(attr_re) && we_q[3] == $past(attr_we))
      else $error("attribute write not stored");
endmodule // had_attr_map

// File: src/had_decoder.sv
// request classifier and router for the memory hub
`timescale 1ns/1ps
module had_decoder #(
   parameter int KT_WIN_LOG2 = 12
) (
   input  wire logic            clock,
   input  wire logic            rstn,
   input  wire logic            req_valid,
   output logic                 req_ready,
   input  wire logic [31:0]     req_addr,
   input  wire had_pkg::had_src_e req_src,
   input  wire logic            req_write,
   input  wire logic [7:0]      req_be,
   input  wire logic            req_mgmt_mode,
   input  wire logic            req_writeback_attr,
   input  wire logic            req_snooped,
   input  wire logic            req_writeback_cycle,
   input  wire logic            req_implicit_writeback,
   input  wire logic            req_full_line,
   input  wire logic            attr_wr,
   input  wire logic [3:0]      attr_sel,
   input  wire logic            attr_re,
   input  wire logic            attr_we,
   input  wire logic [11:0]     low_usable_top,
   input  wire logic [6:0]      gfx_stolen_mb,
   input  wire logic            hole_en,
   input  wire logic            low_mgmt_segment_en,
   input  wire had_pkg::had_lms_e low_mgmt_segment_size,
   input  wire logic            ext_mgmt_memory_en,
   input  wire logic            high_mgmt_segment_en,
   input  wire logic            pcie_window_en,
   input  wire logic [11:0]     pcie_window_base,
   input  wire logic [11:0]     pcie_window_limit,
   input  wire logic            kbd_text_en,
   input  wire logic [31:0]     kbd_text_mmio_base,
   input  wire logic            apic_pcie_en,
   input  wire logic [2:0]      ext_gfx_int_pin,
   output logic                 rsp_valid,
   output had_pkg::had_tgt_e    rsp_target,
   output logic [31:0]          rsp_addr,
   output logic [7:0]           rsp_be,
   output logic                 rsp_write,
   output logic                 rsp_host_term,
   output logic                 hang,
   output logic [12:0]          attr_re_map,
   output logic [12:0]          attr_we_map,
   output logic [2:0]           int_pin_integrated_graphics,
   output logic [2:0]           int_pin_graphics_pcie_port,
   output logic [2:0]           int_pin_ext_graphics,
   output logic [2:0]           int_pin_redirection_function,
   output logic [2:0]           int_pin_host_interface_function,
   output logic [2:0]           int_pin_keyboard_text_function
);
   import had_pkg::*;

   if (KT_WIN_LOG2 < 4 || KT_WIN_LOG2 > 20) begin : g_bad_kt
      $error("kbd text window size out of range");
   end

   had_attr_if  lk ();

   logic        fire;
   logic        is_host;
   logic        is_upstream;
   logic [11:0] addr_mb;
   logic [11:0] stolen_base;
   logic [11:0] lms_mb;
   logic [11:0] lms_base;
   logic        hit_low_dos;
   logic        hit_video;
   logic        hit_pam;
   logic        hit_main;
   logic        hit_hole;
   logic        hit_stolen;
   logic        hit_lms;
   logic        hit_apic_def;
   logic        hit_apic_pcie;
   logic        hit_high_mgmt_segment;
   logic        hit_pcie_win;
   logic        hit_kt;
   logic        high_mgmt_segment_to_dram;
   had_tgt_e    tgt_d;
   logic [31:0] addr_d;
   logic [7:0]  be_d;
   logic        term_d;
   logic        hang_d;

   logic        rsp_valid_q;
   had_tgt_e    rsp_target_q;
   logic [31:0] rsp_addr_q;
   logic [7:0]  rsp_be_q;
   logic        rsp_write_q;
   logic        rsp_term_q;
   logic        hang_q;
   logic [2:0]  pin_ext_q;

   had_attr_map u_attr (
      .clock       (clock),
      .rstn        (rstn),
      .attr_wr     (attr_wr),
      .attr_sel    (attr_sel),
      .attr_re     (attr_re),
      .attr_we     (attr_we),
      .attr_re_map (attr_re_map),
      .attr_we_map (attr_we_map),
      .lk          (lk)
   );

   // a hung device takes nothing more until reset
   assign req_ready   = !hang_q;
   assign fire        = req_valid && !hang_q;
   assign is_host     = req_src == SRC_HOST;
   assign is_upstream = (req_src == SRC_LINK) || (req_src == SRC_PCIE);
   assign lk.addr     = req_addr;
   assign lk.is_write = req_write;

   // low segment sits right under graphics stolen memory at the low top
   assign addr_mb     = req_addr[31:20];
   assign stolen_base = 12'(low_usable_top - {5'h00, gfx_stolen_mb});
   assign lms_mb      = (low_mgmt_segment_size == LMS_1MB) ? LMS_MB_1 :
                        (low_mgmt_segment_size == LMS_2MB) ? LMS_MB_2 : LMS_MB_8;
   assign lms_base    = 12'(stolen_base - lms_mb);

   // region hits
   assign hit_low_dos   = req_addr < VIDEO_LO;
   assign hit_video     = (req_addr >= VIDEO_LO) && (req_addr < PAM_LO);
   assign hit_pam       = lk.hit;
   assign hit_main      = (req_addr > PAM_HI) && (addr_mb < low_usable_top);
   assign hit_hole      = hole_en && had_in_rng(req_addr, HOLE_LO, HOLE_HI);
   assign hit_stolen    = (gfx_stolen_mb != 7'h00) && (addr_mb >= stolen_base);
   assign hit_lms       = low_mgmt_segment_en && (low_mgmt_segment_size != LMS_OFF) &&
                          (addr_mb >= lms_base) && (addr_mb < stolen_base);
   assign hit_apic_def  = had_in_rng(req_addr, APIC_LO, APIC_DEF_HI);
   assign hit_apic_pcie = had_in_rng(req_addr, APIC_PCIE_LO, APIC_HI);
   assign hit_high_mgmt_segment      = high_mgmt_segment_en && had_in_rng(req_addr, HIGH_MGMT_SEGMENT_LO, HIGH_MGMT_SEGMENT_HI);
   assign hit_pcie_win  = pcie_window_en && (addr_mb >= pcie_window_base) &&
                          (addr_mb <= pcie_window_limit);
   assign hit_kt        = kbd_text_en &&
                          (req_addr[31:KT_WIN_LOG2] == kbd_text_mmio_base[31:KT_WIN_LOG2]);
   // writebacks must land so caches stay coherent
   assign high_mgmt_segment_to_dram  = is_host && (req_mgmt_mode || req_writeback_cycle ||
                          req_implicit_writeback || (req_full_line && req_writeback_attr));

   // one target per request, worked out in the cycle it is presented
   always_comb begin
      tgt_d  = TGT_LINK;
      addr_d = req_addr;
      be_d   = req_be;
      term_d = 1'b0;
      if (hit_low_dos) begin
         tgt_d = TGT_DRAM;
      end else if (hit_video) begin
         tgt_d = TGT_LINK;
      end else if (hit_pam) begin
         if (is_upstream && !req_snooped) begin
            tgt_d = TGT_DRAM;
         end else if (lk.enabled) begin
            tgt_d = TGT_DRAM;
         end else begin
            // disabled pieces are never moved; dram there is out of reach except to non-snooped link and pcie cycles
            tgt_d = TGT_LINK;
         end
      end else if (hit_main) begin
         if (hit_hole) begin
            tgt_d = TGT_LINK;
         end else if (hit_stolen) begin
            tgt_d = (req_src == SRC_IGFX) ? TGT_DRAM : TGT_INVALID;
         end else if (hit_lms) begin
            if (!is_host) begin
               tgt_d = TGT_INVALID;
            end else if (req_mgmt_mode) begin
               tgt_d = (ext_mgmt_memory_en && !req_writeback_attr) ? TGT_INVALID : TGT_DRAM;
            end else if (req_writeback_cycle || req_implicit_writeback) begin
               tgt_d = TGT_DRAM;
            end else begin
               tgt_d = TGT_INVALID;
            end
         end else begin
            tgt_d = TGT_DRAM;
         end
      end else if (hit_apic_def) begin
         tgt_d = TGT_LINK;
      end else if (hit_apic_pcie) begin
         tgt_d = apic_pcie_en ? TGT_PCIE : TGT_LINK;
      end else if (hit_high_mgmt_segment) begin
         if (high_mgmt_segment_to_dram) begin
            tgt_d  = TGT_DRAM;
            // offset from the segment base, not raw low bits: the base is not 256 KB aligned
            addr_d = MANAGEMENT_MEMORY_REMAP + (req_addr - HIGH_MGMT_SEGMENT_LO);
         end else begin
            tgt_d  = TGT_INVALID;
            term_d = is_host;
         end
      end else if (hit_pcie_win) begin
         // software keeps this window off the fixed ranges tested above
         tgt_d = TGT_PCIE;
      end else if (hit_kt) begin
         tgt_d = TGT_DRAM;
      end else begin
         tgt_d = TGT_LINK;
      end
      // invalid cycles go out harmless: address zero, writes masked
      if (tgt_d == TGT_INVALID) begin
         addr_d = 32'h0000_0000;
         be_d   = req_write ? 8'h00 : req_be;
      end
   end

   // an implicit writeback pushed to the link has no completion path
   assign hang_d = fire && req_implicit_writeback && (tgt_d == TGT_LINK);

   // response register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rsp_valid_q  <= 1'b0;
         rsp_target_q <= TGT_LINK;
         rsp_addr_q   <= 32'h0000_0000;
         rsp_be_q     <= 8'h00;
         rsp_write_q  <= 1'b0;
         rsp_term_q   <= 1'b0;
      end else begin
         rsp_valid_q  <= fire && !hang_d;
         rsp_target_q <= tgt_d;
         rsp_addr_q   <= addr_d;
         rsp_be_q     <= be_d;
         rsp_write_q  <= req_write;
         rsp_term_q   <= fire && term_d;
      end
   end

   // sticky hang, cleared only by reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hang_q <= 1'b0;
      end else if (hang_d) begin
         hang_q <= 1'b1;
      end
   end

   // external card pin follows its own register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_ext_q <= INT_PIN_A;
      end else begin
         pin_ext_q <= ext_gfx_int_pin;
      end
   end

   assign rsp_valid     = rsp_valid_q;
   assign rsp_target    = rsp_target_q;
   assign rsp_addr      = rsp_addr_q;
   assign rsp_be        = rsp_be_q;
   assign rsp_write     = rsp_write_q;
   assign rsp_host_term = rsp_term_q;
   assign hang          = hang_q;
   // fixed interrupt pin defaults, except the external card pin from its register
   assign int_pin_integrated_graphics     = INT_PIN_A;
   assign int_pin_graphics_pcie_port      = INT_PIN_A;
   assign int_pin_ext_graphics            = pin_ext_q;
   assign int_pin_redirection_function    = INT_PIN_B;
   assign int_pin_host_interface_function = INT_PIN_C;
   assign int_pin_keyboard_text_function  = INT_PIN_A;

   AST_ONE_TARGET: assert property (@(posedge clock) disable iff (!rstn)
      fire && !hang_d |=> rsp_valid_q && $past(tgt_d) == rsp_target_q)
      else $error("request produced no single target");
   AST_PAM_NOSNOOP: assert property (@(posedge clock) disable iff (!rstn)
      fire && hit_pam && is_upstream && !req_snooped |=> rsp_target_q == TGT_DRAM)
      else $error("non-snooped bios hit left dram");
   AST_PAM_DISABLED: assert property (@(posedge clock) disable iff (!rstn)
      fire && hit_pam && (is_host || req_src == SRC_LINK) && req_snooped && !lk.enabled && !hang_d
      |=> rsp_target_q == TGT_LINK) else $error("disabled piece not sent to link");
   AST_HOLE: assert property (@(posedge clock) disable iff (!rstn)
      fire && hole_en && had_in_rng(req_addr, HOLE_LO, HOLE_HI) && !hang_d |=> rsp_target_q == TGT_LINK)
      else $error("hole access not sent to link");
   AST_LMS_FOREIGN: assert property (@(posedge clock) disable iff (!rstn)
      fire && hit_main && !hit_hole && !hit_stolen && hit_lms && !is_host && !hang_d
      |=> rsp_target_q == TGT_INVALID && rsp_addr_q == 32'h0000_0000 && (!rsp_write_q || rsp_be_q == 8'h00))
      else $error("foreign low segment access not invalidated");
   AST_LMS_WB: assert property (@(posedge clock) disable iff (!rstn)
      fire && hit_main && !hit_hole && !hit_stolen && hit_lms && is_host && !req_mgmt_mode && req_writeback_cycle
      |=> rsp_target_q == TGT_DRAM) else $error("low segment writeback lost");
   AST_APIC_LOW: assert property (@(posedge clock) disable iff (!rstn)
      fire && had_in_rng(req_addr, APIC_LO, APIC_DEF_HI) && !hang_d |=> rsp_target_q == TGT_LINK)
      else $error("default interrupt controller access misrouted");
   AST_APIC_HIGH: assert property (@(posedge clock) disable iff (!rstn)
      fire && hit_apic_pcie && apic_pcie_en |=> rsp_target_q == TGT_PCIE)
      else $error("upper apic range not claimed by pcie");
   AST_HIGH_MGMT_SEGMENT_REMAP: assert property (@(posedge clock) disable iff (!rstn)
      fire && hit_high_mgmt_segment && is_host && req_mgmt_mode
      |=> rsp_target_q == TGT_DRAM && rsp_addr_q == MANAGEMENT_MEMORY_REMAP + ($past(req_addr) - HIGH_MGMT_SEGMENT_LO))
      else $error("high segment remap wrong");
   AST_HIGH_MGMT_SEGMENT_TERM: assert property (@(posedge clock) disable iff (!rstn)
      fire && hit_high_mgmt_segment && is_host && !high_mgmt_segment_to_dram |=> rsp_host_term && rsp_target_q == TGT_INVALID)
      else $error("non-mgmt high segment access not terminated");
   AST_HANG: assert property (@(posedge clock) disable iff (!rstn)
      hang_d |=> hang_q && !rsp_valid_q ##1 hang_q && !req_ready) else $error("hang not held");
endmodule // had_decoder

// File: src/had_pkg.sv
// constants and types for the host address decoder
package had_pkg;
   localparam int          ADDR_W        = 32;
   localparam int          PAM_SEGS      = 13;
   localparam int          PAM_SEG_SHIFT = 14;
   localparam logic [5:0]  PAM_SEG_FIRST = 6'h30;
   localparam logic [3:0]  PAM_SYS_IDX   = 4'hC;
   localparam logic [12:0] PAM_RE_RST    = 13'h0000;
   localparam logic [12:0] PAM_WE_RST    = 13'h0000;
   localparam logic [31:0] VIDEO_LO      = 32'h000A_0000;
   localparam logic [31:0] PAM_LO        = 32'h000C_0000;
   localparam logic [31:0] SYS_BIOS_LO   = 32'h000F_0000;
   localparam logic [31:0] PAM_HI        = 32'h000F_FFFF;
   localparam logic [31:0] HOLE_LO       = 32'h00F0_0000;
   localparam logic [31:0] HOLE_HI       = 32'h00FF_FFFF;
   localparam logic [31:0] APIC_LO       = 32'hFEC0_0000;
   localparam logic [31:0] APIC_DEF_HI   = 32'hFEC7_FFFF;
   localparam logic [31:0] APIC_PCIE_LO  = 32'hFEC8_0000;
   localparam logic [31:0] APIC_HI       = 32'hFECF_FFFF;
   localparam logic [31:0] HIGH_MGMT_SEGMENT_LO       = 32'hFEDA_0000;
   localparam logic [31:0] HIGH_MGMT_SEGMENT_HI       = 32'hFEDB_FFFF;
   localparam logic [31:0] MANAGEMENT_MEMORY_REMAP   = 32'h000A_0000;
   localparam logic [11:0] LMS_MB_1      = 12'h001;
   localparam logic [11:0] LMS_MB_2      = 12'h002;
   localparam logic [11:0] LMS_MB_8      = 12'h008;
   // pci interrupt pin encoding
   localparam logic [2:0]  INT_PIN_A     = 3'h1;
   localparam logic [2:0]  INT_PIN_B     = 3'h2;
   localparam logic [2:0]  INT_PIN_C     = 3'h3;

   typedef enum logic [1:0] {SRC_HOST = 2'h0, SRC_LINK = 2'h1, SRC_PCIE = 2'h2, SRC_IGFX = 2'h3} had_src_e;
   typedef enum logic [1:0] {TGT_DRAM = 2'h0, TGT_LINK = 2'h1, TGT_PCIE = 2'h3, TGT_INVALID = 2'h2} had_tgt_e;
   typedef enum logic [1:0] {LMS_1MB = 2'h0, LMS_2MB = 2'h1, LMS_8MB = 2'h2, LMS_OFF = 2'h3} had_lms_e;

   // inclusive range test, used by the pam, hole, apic and high segment decodes
   function automatic logic had_in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      had_in_rng = (a >= lo) && (a <= hi);
   endfunction
endpackage
